/* File: lcc_regs.vh */
`ifndef LCC_REGS_VH
`define LCC_REGS_VH

// ----------------------------------------
// command codes
// ----------------------------------------
`define LCC_CMD_COMP        8'hb1
`define LCC_CMD_STORE_ALL   8'h15
`define LCC_CMD_RESTORE_ALL 8'h16
`define LCC_CMD_OVERRIDE    8'hee

// ----------------------------------------
// word layout
// ----------------------------------------
`define LCC_WORD_W          40
`define LCC_WORD_BYTES      3'h5
`define LCC_CUR_INTEG_HI    25:24
`define LCC_CUR_INTEG_LO    39:38
`define LCC_CUR_FILTER      37:33
`define LCC_CUR_DOUBLE      32
`define LCC_CUR_MIDBAND     31:26
`define LCC_VOLT_INTEG_HI   9:8
`define LCC_VOLT_INTEG_LO   23:22
`define LCC_VOLT_FILTER     21:17
`define LCC_VOLT_MIDBAND    15:10
`define LCC_VOLT_TRANSCOND  5:4
`define LCC_CUR_TRANSCOND   1:0

// ----------------------------------------
// status bits
// ----------------------------------------
`define LCC_CML_IVC_BIT     7
`define LCC_BYTE_CML_BIT    1

`endif

/* File: lcc_loop_comp_config.v */
`timescale 1ns/1ns
`include "lcc_regs.vh"

module lcc_loop_comp_config
#(
  parameter WORD_W = `LCC_WORD_W
)
(
  input  wire              clock,
  input  wire              nrst,
  input  wire              conv_enable,
  input  wire              analog_input_supply_ok,
  input  wire              init_load,
  input  wire              strap_override_mask,
  input  wire [WORD_W-1:0] nvm_word,
  input  wire [WORD_W-1:0] strap_word,
  input  wire              cmd_valid,
  input  wire [7:0]        cmd_code,
  input  wire              cmd_is_write,
  input  wire              cmd_read_only,
  input  wire              wr_byte_valid,
  input  wire [7:0]        wr_byte,
  input  wire              wr_done,
  input  wire              rd_byte_req,
  output reg  [7:0]        rd_byte,
  output reg               rd_byte_valid,
  output wire [7:0]        rd_count,
  output reg               store_req,
  output reg  [WORD_W-1:0] store_word,
  output reg               cml_ivc,
  output wire              status_byte_cml,
  input  wire              cml_clear,
  output reg               host_alert,
  output reg  [WORD_W-1:0] active_word,
  output wire [3:0]        cur_integ_cap_sel,
  output wire [4:0]        cur_filter_cap_sel,
  output wire              cur_integ_cap_double,
  output wire [5:0]        cur_midband_res_sel,
  output wire [3:0]        volt_integ_cap_sel,
  output wire [4:0]        volt_filter_cap_sel,
  output wire [5:0]        volt_midband_res_sel,
  output wire [1:0]        volt_transcond_sel,
  output wire [1:0]        cur_transcond_sel
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg [WORD_W-1:0] user_word;
  reg [WORD_W-1:0] shadow;
  reg [WORD_W-1:0] stored_word;
  reg [2:0]        wr_idx;
  reg [2:0]        rd_idx;
  reg              sel_comp;
  reg              stored_valid;
  reg              supply_prev;

  reg [WORD_W-1:0] next_user_word;
  reg [WORD_W-1:0] next_active_word;
  reg [WORD_W-1:0] next_stored_word;
  reg              next_stored_valid;
  reg              next_store_req;
  reg              next_cml_ivc;

  wire              ivc_event;
  wire              restore_evt;
  wire              supply_recover;
  wire [WORD_W-1:0] init_word;
  wire              write_ok;
  wire              store_evt;
  wire              reload_evt;

  assign ivc_event      = cmd_valid & cmd_is_write & cmd_read_only;
  assign restore_evt    = cmd_valid & cmd_is_write & (cmd_code == `LCC_CMD_RESTORE_ALL);
  assign supply_recover = analog_input_supply_ok & ~supply_prev;
  assign status_byte_cml = cml_ivc;
  assign rd_count       = {5'h00, `LCC_WORD_BYTES};
  assign init_word      = strap_override_mask ? strap_word : nvm_word;
  assign write_ok       = wr_done & sel_comp & (wr_idx == `LCC_WORD_BYTES);
  assign store_evt      = cmd_valid & cmd_is_write & (cmd_code == `LCC_CMD_STORE_ALL);
  assign reload_evt     = (restore_evt | supply_recover) & stored_valid & ~strap_override_mask;

  // ----------------------------------------
  // command capture and byte assembly
  // ----------------------------------------
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      sel_comp <= 1'b0;
      wr_idx   <= 3'h0;
      shadow   <= {WORD_W{1'b0}};
    end
    else
    begin
      if (cmd_valid)
      begin
        sel_comp <= (cmd_code == `LCC_CMD_COMP);
        wr_idx   <= 3'h0;
      end
      else if (wr_byte_valid && sel_comp && wr_idx < `LCC_WORD_BYTES)
      begin
        shadow[wr_idx*8 +: 8] <= wr_byte;
        wr_idx <= wr_idx + 3'h1;
      end
    end
  end

  // ----------------------------------------
  // next values of user and active copies
  // ----------------------------------------
  always @*
  begin
    next_user_word    = user_word;
    next_active_word  = active_word;
    next_stored_word  = stored_word;
    next_stored_valid = stored_valid;
    next_store_req    = 1'b0;
    if (init_load)
    begin
      next_user_word   = init_word;
      next_active_word = init_word;
    end
    else if (write_ok)
    begin
      next_user_word = shadow;
      if (!conv_enable)
        next_active_word = shadow;
    end
    else if (store_evt)
    begin
      next_stored_word  = user_word;
      next_stored_valid = 1'b1;
      next_store_req    = 1'b1;
    end
    else if (reload_evt)
    begin
      next_active_word = stored_word;
      next_user_word   = stored_word;
    end
    // conversion on: active copy left untouched by writes
  end

  // ----------------------------------------
  // user copy and active copy
  // ----------------------------------------
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      user_word    <= {WORD_W{1'b0}};
      active_word  <= {WORD_W{1'b0}};
      stored_word  <= {WORD_W{1'b0}};
      stored_valid <= 1'b0;
      supply_prev  <= 1'b1;
      store_req    <= 1'b0;
      store_word   <= {WORD_W{1'b0}};
    end
    else
    begin
      supply_prev  <= analog_input_supply_ok;
      user_word    <= next_user_word;
      active_word  <= next_active_word;
      stored_word  <= next_stored_word;
      stored_valid <= next_stored_valid;
      store_req    <= next_store_req;
      store_word   <= next_stored_word;
    end
  end

  // ----------------------------------------
  // block read
  // ----------------------------------------
  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      rd_idx        <= 3'h0;
      rd_byte       <= 8'h00;
      rd_byte_valid <= 1'b0;
    end
    else
    begin
      rd_byte_valid <= 1'b0;
      if (cmd_valid)
        rd_idx <= 3'h0;
      else if (rd_byte_req && sel_comp && rd_idx < `LCC_WORD_BYTES)
      begin
        rd_byte       <= user_word[rd_idx*8 +: 8];
        rd_byte_valid <= 1'b1;
        rd_idx        <= rd_idx + 3'h1;
      end
    end
  end

  // ----------------------------------------
  // invalid command fault
  // ----------------------------------------
  // set wins over a clear in the same cycle
  always @*
  begin
    next_cml_ivc = cml_ivc;
    if (ivc_event)
      next_cml_ivc = 1'b1;
    else if (cml_clear)
      next_cml_ivc = 1'b0;
  end

  always @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      cml_ivc    <= 1'b0;
      host_alert <= 1'b0;
    end
    else
    begin
      cml_ivc    <= next_cml_ivc;
      host_alert <= next_cml_ivc;
    end
  end

  // ----------------------------------------
  // field decode of active copy
  // ----------------------------------------
  assign cur_integ_cap_sel    = {active_word[`LCC_CUR_INTEG_HI],
                                 active_word[`LCC_CUR_INTEG_LO]};
  assign cur_filter_cap_sel   = active_word[`LCC_CUR_FILTER];
  assign cur_integ_cap_double = active_word[`LCC_CUR_DOUBLE];
  assign cur_midband_res_sel  = active_word[`LCC_CUR_MIDBAND];
  assign volt_integ_cap_sel   = {active_word[`LCC_VOLT_INTEG_HI],
                                 active_word[`LCC_VOLT_INTEG_LO]};
  assign volt_filter_cap_sel  = active_word[`LCC_VOLT_FILTER];
  assign volt_midband_res_sel = active_word[`LCC_VOLT_MIDBAND];
  assign volt_transcond_sel   = active_word[`LCC_VOLT_TRANSCOND];
  assign cur_transcond_sel    = active_word[`LCC_CUR_TRANSCOND];

endmodule

/* File: lcc_loop_comp_config_chk.sv */
`timescale 1ns/1ns
// ------------------
// loop compensation checker
// ------------------
module lcc_chk
#(
  parameter WORD_W = 40
)
(
  input wire              clock, nrst, conv_enable, init_load, wr_done, cml_clear,
  input wire              cmd_valid, cmd_is_write, cmd_read_only, rd_byte_req,
  input wire              rd_byte_valid, cml_ivc, status_byte_cml, host_alert,
  input wire [7:0]        rd_count,
  input wire [WORD_W-1:0] active_word,
  input wire [3:0]        cur_integ_cap_sel, volt_integ_cap_sel,
  input wire [4:0]        cur_filter_cap_sel, volt_filter_cap_sel,
  input wire [5:0]        cur_midband_res_sel, volt_midband_res_sel,
  input wire              cur_integ_cap_double,
  input wire [1:0]        volt_transcond_sel, cur_transcond_sel
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  fault_set_a: assert property (cmd_valid && cmd_is_write && cmd_read_only
    |=> cml_ivc && host_alert) else $error("fault flag not raised");
  fault_wins_a: assert property (cmd_valid && cmd_read_only && cmd_is_write && cml_clear
    |=> cml_ivc) else $error("clear beat fault set");
  fault_hold_a: assert property (cml_ivc && !cml_clear |=> cml_ivc)
    else $error("fault flag dropped");
  status_mirror_a: assert property (status_byte_cml == cml_ivc)
    else $error("status summary differs");
  read_answer_a: assert property (rd_byte_req |=> rd_byte_valid)
    else $error("read byte late");
  byte_count_a: assert property (rd_count == 8'h05)
    else $error("block count wrong");
  active_hold_a: assert property (conv_enable && wr_done && !init_load
    |=> $stable(active_word)) else $error("active copy changed");
  cur_fields_a: assert property ({cur_integ_cap_sel, cur_filter_cap_sel,
    cur_integ_cap_double, cur_midband_res_sel, cur_transcond_sel} == {active_word[25:24],
    active_word[39:38], active_word[37:26], active_word[1:0]}) else $error("current fields");
  volt_fields_a: assert property ({volt_integ_cap_sel, volt_filter_cap_sel,
    volt_midband_res_sel, volt_transcond_sel} == {active_word[9:8], active_word[23:22],
    active_word[21:17], active_word[15:10], active_word[5:4]}) else $error("voltage fields");
  cover property (cmd_valid && cmd_read_only);
  cover property (conv_enable && wr_done);
  cover property (!conv_enable && wr_done);
endmodule

bind lcc_loop_comp_config lcc_chk #(.WORD_W(WORD_W)) chk (.*);

/* File: lcc_host.sv */
`timescale 1ns/1ns
// ------------------
// block read and write host
// ------------------
module lcc_host
(
  input  wire       clock,
  output reg        cmd_valid, cmd_is_write, cmd_read_only,
  output reg        wr_byte_valid, wr_done, rd_byte_req,
  output reg  [7:0] cmd_code, wr_byte,
  input  wire [7:0] rd_byte
);
  integer i;
  initial {cmd_valid, cmd_is_write, cmd_read_only, wr_byte_valid, wr_done, rd_byte_req} = 0;
  initial {cmd_code, wr_byte} = 16'h5a5a;
  task cmd(input [7:0] c, input w, input ro);
    begin
      {cmd_valid, cmd_code, cmd_is_write, cmd_read_only} = {1'b1, c, w, ro};
      @(negedge clock);
      cmd_valid = 0;
      cmd_code = ~c;
    end
  endtask
  task wr_word(input [39:0] w, input integer n);
    begin
      cmd(8'hb1, 1, 0);
      for (i = 0; i < n; i = i + 1)
      begin
        wr_byte_valid = 1;
        wr_byte = w[8*i+:8];
        @(negedge clock);
      end
      wr_byte_valid = 0;
      wr_byte = ~wr_byte;
      wr_done = 1;
      @(negedge clock);
      wr_done = 0;
    end
  endtask
  task rd_word(output [39:0] w);
    begin
      cmd(8'hb1, 0, 0);
      for (i = 0; i < 5; i = i + 1)
      begin
        rd_byte_req = 1;
        @(negedge clock);
        rd_byte_req = 0;
        w[8*i+:8] = rd_byte;
        @(negedge clock);
      end
    end
  endtask
endmodule

/* File: tb_lcc_loop_comp_config.sv */
`timescale 1ns/1ns
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
  $display("MISMATCH %0t got %h want %h", $time, a, b); end end
// ------------------
// compensation register bench
// ------------------
module tb_lcc_loop_comp_config;
  reg clock = 0, nrst = 0, conv_enable = 0, analog_input_supply_ok = 1, init_load = 0;
  reg strap_override_mask = 0, cml_clear = 0;
  reg [39:0] nvm_word = 0, strap_word = 0, w, w2, r;
  reg [31:0] seed = 91;
  integer n_fail = 0, tests_run = 0, cyc = 0, k;
  wire [7:0] cmd_code, wr_byte, rd_byte, rd_count;
  wire cmd_valid, cmd_is_write, cmd_read_only, wr_byte_valid, wr_done, rd_byte_req;
  wire rd_byte_valid, store_req, cml_ivc, status_byte_cml, host_alert, cur_integ_cap_double;
  wire [39:0] store_word, active_word;
  wire [3:0] cur_integ_cap_sel, volt_integ_cap_sel;
  wire [4:0] cur_filter_cap_sel, volt_filter_cap_sel;
  wire [5:0] cur_midband_res_sel, volt_midband_res_sel;
  wire [1:0] volt_transcond_sel, cur_transcond_sel;
  lcc_loop_comp_config uut (.*);
  lcc_host host (.*);
  function [39:0] rnd;
    begin
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      rnd = {seed[7:0], seed} & ~40'h00000100cc;
    end
  endfunction
  task tick(input integer n);
    repeat (n) @(negedge clock);
  endtask
  task conclude;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial
  begin
    forever #2 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cyc = cyc + 1;
    if (cyc == 3000)
    begin
      n_fail++;
      conclude;
    end
  end
  initial
  begin
    tick(2);
    nrst = 1;
    nvm_word = rnd();
    strap_word = rnd();
    for (k = 0; k < 2; k++)
    begin
      strap_override_mask = k;
      init_load = 1;
      tick(1);
      init_load = 0;
      tick(1);
      `CHK(active_word, k ? strap_word : nvm_word)
    end
    strap_override_mask = 0;
    $display("test init done");
    for (k = 0; k < 5; k++)
    begin
      w = k ? rnd() : ~40'h00000100cc;
      host.wr_word(w, 5);
      tick(1);
      `CHK(active_word, w)
      host.rd_word(r);
      `CHK(r, w)
    end
    host.wr_word(~w, 4);
    tick(1);
    `CHK(active_word, w)
    host.cmd(8'had, 1, 1);
    `CHK({cml_ivc, host_alert}, 2'b11)
    cml_clear = 1;
    tick(1);
    cml_clear = 0;
    tick(1);
    `CHK(cml_ivc, 1'b0)
    cml_clear = 1;
    host.cmd(8'had, 1, 1);
    cml_clear = 0;
    `CHK({cml_ivc, status_byte_cml}, 2'b11)
    cml_clear = 1;
    tick(1);
    cml_clear = 0;
    tick(1);
    $display("test direct write done");
    conv_enable = 1;
    for (k = 0; k < 2; k++)
    begin
      w2 = rnd();
      host.wr_word(w2, 5);
      tick(1);
      `CHK(active_word, w)
      host.rd_word(r);
      `CHK(r, w2)
      host.cmd(8'h15, 1, 0);
      `CHK({store_req, store_word}, {1'b1, w2})
      tick(4);
      if (k == 0)
        host.cmd(8'h16, 1, 0);
      else
        analog_input_supply_ok = 0;
      tick(3);
      analog_input_supply_ok = 1;
      tick(4);
      `CHK(active_word, w2)
      w = w2;
    end
    $display("test blocked update done");
    conclude;
  end
endmodule
